// ==== wrs_regs.vh ====
// Constants for the watchdog and reset supervisor
`ifndef WRS_REGS_VH
`define WRS_REGS_VH
// Control word bit positions
`define WRS_BIT_PER0 0
`define WRS_BIT_PER1 1
`define WRS_BIT_PER2 2
`define WRS_BIT_RUN 3
`define WRS_BIT_UNLOCK 4
`define WRS_BIT_PER3 5
`define WRS_BIT_IRQEN 6
`define WRS_BIT_IRQFLAG 7
// Reset values
`define WRS_RST_PERIOD 4'h0
`define WRS_RST_CTRL 8'h00
// Timed window length in system clock cycles
`define WRS_UNLOCK_CYCLES 3'h4
// Period codes
`define WRS_PERIOD_MAX 4'h9
`define WRS_BASE_SHIFT 11
// Oscillator rate in Hz
`define WRS_OSC_HZ 128000
// Default start-up time-out in microseconds, count at 50 MHz
`define WRS_TOUT_US 64
`define WRS_CLK_MHZ 50
`define WRS_TOUT_CYCLES (`WRS_TOUT_US * `WRS_CLK_MHZ)
// Default brown-out filter time in ns, count at 20 ns per cycle
`define WRS_BOD_NS 2000
`define WRS_BOD_CYCLES (`WRS_BOD_NS / 20)
`endif

// ==== wrs_watchdog_reset_supervisor.v ====
// Watchdog timer and reset-source supervisor
`timescale 1ns/10ps
`include "wrs_regs.vh"

module wrs_watchdog_reset_supervisor #(
	parameter TOUT_CYCLES = `WRS_TOUT_CYCLES,
	parameter BOD_CYCLES = `WRS_BOD_CYCLES
) (
	input wire clk, // System clock, 50 MHz
	input wire nrst, // Power-on reset, active low
	input wire clkEn, // Freezes all state while low
	input wire extResetEnable, // Reset pin function enabled
	input wire resetPin_n, // Reset pin, active low, asynchronous
	input wire brownoutEnable, // Brown-out detection fuse-enabled
	input wire [2:0] brownoutLevelFuse, // Trigger level fuse bits
	input wire supplyAboveUpper, // Comparator: supply above level + hyst/2
	input wire supplyBelowLower, // Comparator: supply below level - hyst/2
	input wire comparatorBandgapSelect, // Comparator uses bandgap
	input wire converterEnable, // Converter enabled
	input wire alwaysOnFuse, // Always-on fuse programmed (level 2)
	input wire wdOscTick, // Watchdog oscillator clock, 128 kHz
	input wire watchdogRestart, // Restart instruction pulse
	input wire ctrlWrite, // Control word write strobe
	input wire [7:0] ctrlWdata, // Control word write data
	input wire flagWrite, // Reset-cause flag write strobe
	input wire flagWdata, // Value written to watchdog reset flag
	output reg [7:0] ctrlRdata, // Control word read back
	output reg watchdogResetFlag, // Watchdog caused last reset
	output reg watchdogIrq, // Time-out interrupt / wake request
	output reg watchdogResetPulse, // One-cycle watchdog reset
	output reg coreReset, // Reset held on core
	output reg bandgapPower, // Bandgap reference power enable
	output reg [2:0] brownoutLevelSel // Level select to analog comparator
);

// ==========================================================
// Asynchronous pin reset capture
wire pinLow = extResetEnable & ~resetPin_n;
wire anyRstN = nrst & ~pinLow;
reg pinSync1, pinSync2;
// Release of pin reset synchronised, captured without clock
// Assertion is asynchronous so a stopped clock still resets
// Release passes two stages so the delay never starts on a glitch
always @(posedge clk or negedge anyRstN) begin
	if (!anyRstN) begin
		pinSync1 <= 1'b0;
		pinSync2 <= 1'b0;
	end else if (clkEn) begin
		pinSync1 <= 1'b1;
		pinSync2 <= pinSync1;
	end
end

// ==========================================================
// Brown-out filter with hysteresis
reg belowS1, belowS2, aboveS1, aboveS2, brownout;
reg [15:0] bodCnt;
// Input synchronisers for comparator levels
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		belowS1 <= 1'b0;
		belowS2 <= 1'b0;
		aboveS1 <= 1'b1;
		aboveS2 <= 1'b1;
	end else if (clkEn) begin
		belowS1 <= supplyBelowLower;
		belowS2 <= belowS1;
		aboveS1 <= supplyAboveUpper;
		aboveS2 <= aboveS1;
	end
end
// Flag only drops that persist past filter time
reg next_brownout;
reg [15:0] next_bodCnt;
always @* begin
	next_brownout = brownout;
	next_bodCnt = bodCnt;
	if (!brownoutEnable) begin
		next_bodCnt = 16'h0000;
		next_brownout = 1'b0;
	end else if (brownout) begin
		// Clears only above the upper hysteresis edge
		next_bodCnt = 16'h0000;
		if (aboveS2)
			next_brownout = 1'b0;
	end else if (belowS2) begin
		if (bodCnt >= BOD_CYCLES[15:0])
			next_brownout = 1'b1;
		else
			next_bodCnt = bodCnt + 16'h0001;
	end else begin
		// A dip that ends early starts over
		next_bodCnt = 16'h0000;
	end
end
// Filter registers and level select mirror
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		bodCnt <= 16'h0000;
		brownout <= 1'b0;
		brownoutLevelSel <= 3'h0;
	end else if (clkEn) begin
		brownoutLevelSel <= brownoutLevelFuse;
		bodCnt <= next_bodCnt;
		brownout <= next_brownout;
	end
end

// ==========================================================
// Watchdog oscillator domain: tick edge synchronised
// Two stages settle the foreign clock, the third finds its rising edge
// The oscillator must stay well below half the system clock rate
reg tickS1, tickS2, tickS3;
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		tickS1 <= 1'b0;
		tickS2 <= 1'b0;
		tickS3 <= 1'b0;
	end else if (clkEn) begin
		tickS1 <= wdOscTick;
		tickS2 <= tickS1;
		tickS3 <= tickS2;
	end
end
wire oscEdge = tickS2 & ~tickS3;

// ==========================================================
// Control register and timed change window
reg run, irqEn, unlock, irqFlag;
reg [3:0] period;
reg [2:0] unlockCnt;
reg [20:0] wdCnt;
reg next_run, next_irqEn, next_unlock, next_irqFlag;
reg [3:0] next_period;
reg [2:0] next_unlockCnt;
wire level2 = alwaysOnFuse;
wire effRun = level2 | run | watchdogResetFlag;
wire active = effRun | irqEn;
wire wUnlock = ctrlWdata[`WRS_BIT_UNLOCK];
wire wRun = ctrlWdata[`WRS_BIT_RUN];
wire [3:0] wPer = {ctrlWdata[`WRS_BIT_PER3], ctrlWdata[`WRS_BIT_PER2],
	ctrlWdata[`WRS_BIT_PER1], ctrlWdata[`WRS_BIT_PER0]};
wire [20:0] limit = (period > `WRS_PERIOD_MAX) ? 21'h1FFFFF :
	((21'h000001 << (`WRS_BASE_SHIFT + period)) - 21'h000001);
// Reserved period codes never expire; the counter just wraps
wire validPer = (period <= `WRS_PERIOD_MAX);
wire expire = active & oscEdge & validPer & (wdCnt >= limit);
wire rstAction = expire & effRun & ~irqEn;
wire irqAction = expire & irqEn;
// First write of a timed sequence must carry unlock and run together
wire firstWrite = ctrlWrite & wUnlock & wRun;
wire finalWrite = ctrlWrite & ~firstWrite & unlock;

// Window opens on a valid first write and shuts after four clocks
always @* begin
	next_unlock = unlock;
	next_unlockCnt = unlockCnt;
	if (unlock) begin
		if (unlockCnt == `WRS_UNLOCK_CYCLES - 3'h1)
			next_unlock = 1'b0;
		next_unlockCnt = unlockCnt + 3'h1;
	end
	if (firstWrite) begin
		next_unlock = 1'b1;
		next_unlockCnt = 3'h0;
	end else if (finalWrite) begin
		next_unlock = 1'b0; // Used up by the final write
	end
end

// Protected settings: clearing the run bit; period select only at level 2
always @* begin
	next_run = run;
	next_period = period;
	if (firstWrite) begin
		if (!level2)
			next_run = 1'b1;
	end else if (finalWrite) begin
		next_period = wPer;
		if (!level2)
			next_run = wRun;
	end else if (ctrlWrite && !level2) begin
		next_period = wPer;
		if (wRun)
			next_run = 1'b1;
	end
end

// Interrupt enable and flag
always @* begin
	next_irqEn = irqEn;
	next_irqFlag = irqFlag;
	if (ctrlWrite)
		next_irqEn = ctrlWdata[`WRS_BIT_IRQEN];
	// Combined mode: the time-out drops the enable, next one resets
	if (expire && effRun && irqEn)
		next_irqEn = 1'b0;
	// Set wins over a software clear in the same cycle
	if (irqAction)
		next_irqFlag = 1'b1;
	else if (ctrlWrite && ctrlWdata[`WRS_BIT_IRQFLAG])
		next_irqFlag = 1'b0;
end

// Control state, cleared by power-on or by the reset pin
always @(posedge clk or negedge anyRstN) begin
	if (!anyRstN) begin
		run <= 1'b0;
		irqEn <= 1'b0;
		unlock <= 1'b0;
		unlockCnt <= 3'h0;
		period <= `WRS_RST_PERIOD;
		irqFlag <= 1'b0;
	end else if (clkEn) begin
		run <= next_run;
		irqEn <= next_irqEn;
		unlock <= next_unlock;
		unlockCnt <= next_unlockCnt;
		period <= next_period;
		irqFlag <= next_irqFlag;
	end
end

// ==========================================================
// Watchdog counter
// Held clear while stopped, restarted, expired or the core is in reset
always @(posedge clk or negedge anyRstN) begin
	if (!anyRstN) begin
		wdCnt <= 21'h000000;
	end else if (clkEn) begin
		if (!active || watchdogRestart || expire || coreReset)
			wdCnt <= 21'h000000;
		else if (oscEdge)
			wdCnt <= wdCnt + 21'h000001;
	end
end

// ==========================================================
// Reset pulse, flag and start-up delay
reg [23:0] delayCnt;
reg [23:0] next_delayCnt;
reg next_coreReset, next_resetFlag;
// Any source holds the core; the count restarts until all are gone
wire holdReset = !pinSync2 || brownout || rstAction ||
	watchdogResetPulse;

// Flag survives pin and watchdog resets; set wins over a clear
always @* begin
	next_resetFlag = watchdogResetFlag;
	if (rstAction)
		next_resetFlag = 1'b1;
	else if (flagWrite && !flagWdata)
		next_resetFlag = 1'b0;
end

// Start-up delay begins once the pulse has fallen
always @* begin
	next_delayCnt = delayCnt;
	next_coreReset = coreReset;
	if (holdReset) begin
		next_delayCnt = 24'h000000;
		next_coreReset = 1'b1;
	end else if (delayCnt >= TOUT_CYCLES[23:0]) begin
		next_coreReset = 1'b0;
	end else begin
		next_delayCnt = delayCnt + 24'h000001;
	end
end

// One-clock watchdog reset pulse and its flag
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		watchdogResetPulse <= 1'b0;
		watchdogResetFlag <= 1'b0;
	end else if (clkEn) begin
		watchdogResetPulse <= rstAction & ~watchdogResetPulse;
		watchdogResetFlag <= next_resetFlag;
	end
end

// Core reset raised at once by the pin, with or without a clock
always @(posedge clk or negedge anyRstN) begin
	if (!anyRstN) begin
		delayCnt <= 24'h000000;
		coreReset <= 1'b1;
	end else if (clkEn) begin
		delayCnt <= next_delayCnt;
		coreReset <= next_coreReset;
	end
end

// ==========================================================
// Outputs and bandgap
reg [7:0] next_rdata;
reg next_irq;
// Read-back word; run bit shows the effective enable
always @* begin
	next_rdata = {irqFlag, irqEn, period[3], unlock, effRun,
		period[2:0]};
	// A pending flag still raises the request in combined mode
	next_irq = irqFlag & (irqEn | effRun);
end

// Readback and interrupt registers
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		ctrlRdata <= `WRS_RST_CTRL;
		watchdogIrq <= 1'b0;
	end else if (clkEn) begin
		ctrlRdata <= next_rdata;
		watchdogIrq <= next_irq;
	end
end

// Bandgap powered by any of its three users
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		bandgapPower <= 1'b0;
	end else if (clkEn) begin
		bandgapPower <= brownoutEnable | comparatorBandgapSelect |
			converterEnable;
	end
end

endmodule

// ==== wrs_watchdog_reset_supervisor_assertions.sv ====
// Checker for the watchdog and reset supervisor
`timescale 1ns/10ps
module wrs_sva (
	input wire clk, // Clock
	input wire nrst, // Reset
	input wire extResetEnable, // Pin on
	input wire resetPin_n, // Pin
	input wire brownoutEnable, // Fuse
	input wire supplyBelowLower, // Sag
	input wire comparatorBandgapSelect, // Select
	input wire converterEnable, // Converter
	input wire alwaysOnFuse, // Level 2
	input wire [7:0] ctrlRdata, // Readback
	input wire watchdogResetFlag, // Flag
	input wire watchdogResetPulse, // Pulse
	input wire coreReset, // Core reset
	input wire bandgapPower // Bandgap
);
	// ==========
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire [2:0] bgIn = {brownoutEnable, comparatorBandgapSelect, converterEnable};
	sequence pinHeld;
		(extResetEnable && !resetPin_n) [*3];
	endsequence
	sequence sagLong;
		(brownoutEnable && supplyBelowLower) [*8];
	endsequence
	sequence dipShort;
		!coreReset && !supplyBelowLower ##1 supplyBelowLower
			##1 !supplyBelowLower;
	endsequence
	pulse_one_a: assert property (
		watchdogResetPulse |=> !watchdogResetPulse) else $error("long pulse");
	delay_start_a: assert property (
		$fell(watchdogResetPulse) |-> coreReset [*8]) else $error("no delay");
	flag_set_a: assert property (
		watchdogResetPulse |-> ##[0:3] watchdogResetFlag) else $error("no flag");
	pin_release_a: assert property (
		pinHeld ##1 resetPin_n |-> coreReset [*8]) else $error("pin early");
	sag_reset_a: assert property (
		sagLong |-> ##[0:4] coreReset) else $error("no sag reset");
	dip_ignored_a: assert property (
		dipShort |-> !coreReset [*6]) else $error("dip reset");
	bandgap_on_a: assert property (
		$stable(bgIn) [*3] |-> bandgapPower == (bgIn != 3'h0))
		else $error("bandgap wrong");
	run_forced_a: assert property (
		(alwaysOnFuse && resetPin_n) [*4] |-> ctrlRdata[3])
		else $error("run low");
	unlock_close_a: assert property (
		$rose(ctrlRdata[4]) |-> ##[1:5] !ctrlRdata[4]) else $error("open");
endmodule
bind wrs_watchdog_reset_supervisor wrs_sva chk (.clk, .nrst,
	.extResetEnable, .resetPin_n, .brownoutEnable, .supplyBelowLower,
	.comparatorBandgapSelect, .converterEnable, .alwaysOnFuse, .ctrlRdata,
	.watchdogResetFlag, .watchdogResetPulse, .coreReset, .bandgapPower);

// ==== wrs_watchdog_reset_supervisor_tb_top.sv ====
// Testbench for the watchdog and reset supervisor
`timescale 1ns/10ps
module wrs_watchdog_reset_supervisor_tb_top;
	reg clk = 0, nrst = 0, xEn = 0, pin = 1, bEn = 0, sLow = 0, comparator_bandgap_select = 0;
	reg adc = 0, aon = 0, osc = 0, cw = 0, fw = 0, rs = 0;
	reg [2:0] lvl = 3'h0;
	reg [1:0] k = 2'h0;
	reg [7:0] cd = 8'h00;
	wire [7:0] rd;
	wire [2:0] ls;
	wire flg, irq, pls, cr, bg;
	integer n_mismatch = 0, tests_run = 0, i, j;
	// ==========
	// Design and stimulus clocks
	wrs_watchdog_reset_supervisor #(.TOUT_CYCLES(8), .BOD_CYCLES(4)) DUT (
		.clk(clk), .nrst(nrst), .clkEn(1'b1), .extResetEnable(xEn),
		.resetPin_n(pin), .brownoutEnable(bEn), .brownoutLevelFuse(lvl),
		.supplyAboveUpper(!sLow), .supplyBelowLower(sLow),
		.comparatorBandgapSelect(comparator_bandgap_select), .converterEnable(adc),
		.alwaysOnFuse(aon), .wdOscTick(osc), .watchdogRestart(rs),
		.ctrlWrite(cw), .ctrlWdata(cd), .flagWrite(fw), .flagWdata(1'b0),
		.ctrlRdata(rd), .watchdogResetFlag(flg), .watchdogIrq(irq),
		.watchdogResetPulse(pls), .coreReset(cr), .bandgapPower(bg),
		.brownoutLevelSel(ls));
	always #10 clk = ~clk;
	// Oscillator stand-in, four clocks a period
	always @(posedge clk) begin
		k <= k + 2'h1;
		osc <= k[1];
	end
	// ==========
	// Shared tasks
	task chk(input s, input e);
		begin
			tests_run = tests_run + 1;
			if (s !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("BAD %0t seen %b want %b", $time, s, e);
			end
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task wr(input [7:0] d);
		begin
			@(posedge clk);
			cw <= 1'b1;
			cd <= d;
			@(posedge clk);
			cw <= 1'b0;
		end
	endtask
	task rel;
		begin
			i = 0;
			while (cr !== 1'b0 && i < 300) begin
				@(posedge clk);
				i = i + 1;
			end
			chk(i > 7 && i < 20, 1'b1);
		end
	endtask
	task wait_on(input integer sig);
		begin
			i = 0;
			while ((sig ? irq : pls) !== 1'b1 && i < 9000) begin
				@(posedge clk);
				i = i + 1;
			end
		end
	endtask
	// ==========
	// Scenarios
	task t_bg;
		begin
			for (j = 0; j < 8; j = j + 1) begin
				{bEn, comparator_bandgap_select, adc} <= j[2:0];
				lvl <= j[2:0];
				cyc(4);
				chk(bg, |j[2:0]);
				chk(ls === j[2:0], 1'b1);
			end
			bEn <= 1'b0;
		end
	endtask
	task t_rs;
		begin
			wr(8'h08);
			cyc(6000);
			rs <= 1'b1;
			cyc(1);
			rs <= 1'b0;
			wait_on(0);
			chk(i > 8100 && i < 8300, 1'b1);
			rel;
			fw <= 1'b1;
			cyc(1);
			fw <= 1'b0;
			wr(8'h18);
			wr(8'h00);
		end
	endtask
	task t_l1;
		begin
			wr(8'h08);
			wr(8'h00);
			cyc(3);
			chk(rd[3], 1'b1);
			wr(8'h10);
			wr(8'h00);
			cyc(3);
			chk(rd[3], 1'b1);
			wr(8'h18);
			cyc(6);
			wr(8'h00);
			cyc(3);
			chk(rd[3], 1'b1);
			wr(8'h18);
			wr(8'h00);
			cyc(3);
			chk(rd[3], 1'b0);
		end
	endtask
	task t_wd;
		begin
			wr(8'h08);
			wait_on(0);
			chk(i > 8100 && i < 8300, 1'b1);
			rel;
			cyc(3);
			chk(flg, 1'b1);
			wr(8'h18);
			wr(8'h00);
			cyc(3);
			chk(rd[3], 1'b1);
			fw <= 1'b1;
			cyc(1);
			fw <= 1'b0;
			wr(8'h18);
			wr(8'h00);
			cyc(3);
			chk(rd[3], 1'b0);
		end
	endtask
	task t_irq;
		begin
			wr(8'h40);
			wait_on(1);
			chk(irq, 1'b1);
			chk(cr, 1'b0);
			wr(8'hC0);
			cyc(3);
			chk(irq, 1'b0);
		end
	endtask
	task t_pin;
		begin
			xEn <= 1'b1;
			pin <= 1'b0;
			cyc(5);
			chk(cr, 1'b1);
			pin <= 1'b1;
			rel;
		end
	endtask
	task brownout_filter_time;
		begin
			bEn <= 1'b1;
			sLow <= 1'b1;
			cyc(1);
			sLow <= 1'b0;
			cyc(8);
			chk(cr, 1'b0);
			sLow <= 1'b1;
			cyc(12);
			chk(cr, 1'b1);
			sLow <= 1'b0;
			rel;
		end
	endtask
	task t_l2;
		begin
			aon <= 1'b1;
			wr(8'h00);
			cyc(3);
			chk(rd[3], 1'b1);
			wr(8'h18);
			wr(8'h01);
			wr(8'h02);
			cyc(3);
			chk(rd === 8'h09, 1'b1);
		end
	endtask
	task conclude;
		begin
			if (n_mismatch == 0 && tests_run > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// Main sequence
	initial begin
		cyc(6);
		nrst <= 1'b1;
		rel;
		t_bg;
		t_l1;
		t_wd;
		t_rs;
		t_irq;
		t_pin;
		brownout_filter_time;
		t_l2;
		conclude;
	end
	// Hang guard
	initial begin
		#1600000;
		n_mismatch = n_mismatch + 1;
		conclude;
	end
endmodule
